// [shared/irq2_flags_regs.svh]
// register indices, byte addresses, field positions and reset values
`ifndef IRQ2_FLAGS_REGS_SVH
`define IRQ2_FLAGS_REGS_SVH

// register indices; byte address is four times the index
`define GPIO_MID_IRQ_FLAGS_IDX 16'h1910
`define GPIO_UPPER_IRQ_FLAGS_IDX 16'h1912
`define TIMER_IRQ_FLAGS_IDX 16'h1914
`define GPIO_MID_IRQ_MASK_IDX 16'h1990
`define GPIO_UPPER_IRQ_MASK_IDX 16'h1992
`define TIMER_IRQ_MASK_IDX 16'h1994
`define BYTE_ADDR(idx) ((idx) << 2)

// field positions
`define PIN17_EDGE_FLAG_BIT 0
`define PIN20_EDGE_FLAG_BIT 3
`define PIN33_EDGE_FLAG_BIT 0
`define PIN40_EDGE_FLAG_BIT 7
`define TMR1_RISE_FLAG_BIT 0
`define TMR2_RISE_FLAG_BIT 1
`define TMR8_RISE_FLAG_BIT 7

// reset values
`define FLAGS_RST_MID 4'h0
`define FLAGS_RST_UPPER 8'h00
`define FLAGS_RST_TMR 8'h00
`define MASK_RST_MID 4'hf
`define MASK_RST_UPPER 8'hff
`define MASK_RST_TMR 8'hff

// cycles after reset release before pin edges count
`define PIN_PRIME_CYCLES 2'h3

`endif

// [shared/irq2_flags_pkg.sv]
// types shared by the interrupt flag bank
package irq2_flags_pkg;

   // one bit per event source, same layout for flags and masks
   typedef struct packed
   {
      logic [3:0] gpioMid;
      logic [7:0] gpioUpper;
      logic [7:0] tmr;
   } flags_t;

   // register selected by an apb address
   typedef enum logic [2:0]
   {
      SEL_NONE = 3'b000,
      SEL_MID_FLAGS = 3'b001,
      SEL_UPPER_FLAGS = 3'b010,
      SEL_TMR_FLAGS = 3'b011,
      SEL_MID_MASK = 3'b100,
      SEL_UPPER_MASK = 3'b101,
      SEL_TMR_MASK = 3'b110
   } reg_sel_t;

endpackage

// [logic/irq2_gpio_timer_status_flags.sv]
// sticky gpio and timer interrupt flags with masks behind an apb slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "irq2_flags_regs.svh"

module irq2_gpio_timer_status_flags
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] gpioLowPin,
   input wire logic [7:0] gpioHighPin,
   input wire logic [7:0] tmrEvent,
   output logic irqOut
);

   ////////////////////////////////////////////////////////////////////////
   // address decode, shared by read and write paths
   function automatic irq2_flags_pkg::reg_sel_t decodeSel
   (
      input logic [15:0] addr
   );
      irq2_flags_pkg::reg_sel_t sel;
      case (addr)
         `BYTE_ADDR(`GPIO_MID_IRQ_FLAGS_IDX):
            sel = irq2_flags_pkg::SEL_MID_FLAGS;
         `BYTE_ADDR(`GPIO_UPPER_IRQ_FLAGS_IDX):
            sel = irq2_flags_pkg::SEL_UPPER_FLAGS;
         `BYTE_ADDR(`TIMER_IRQ_FLAGS_IDX):
            sel = irq2_flags_pkg::SEL_TMR_FLAGS;
         `BYTE_ADDR(`GPIO_MID_IRQ_MASK_IDX):
            sel = irq2_flags_pkg::SEL_MID_MASK;
         `BYTE_ADDR(`GPIO_UPPER_IRQ_MASK_IDX):
            sel = irq2_flags_pkg::SEL_UPPER_MASK;
         `BYTE_ADDR(`TIMER_IRQ_MASK_IDX):
            sel = irq2_flags_pkg::SEL_TMR_MASK;
         default:
            sel = irq2_flags_pkg::SEL_NONE;
      endcase
      return sel;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [11:0] pinRaw;
   logic [11:0] pinMeta_r;
   logic [11:0] pinMeta_nxt;
   logic [11:0] pinSync2_r;
   logic [11:0] pinSync2_nxt;
   logic [11:0] pinSync3_r;
   logic [11:0] pinSync3_nxt;
   logic [11:0] pinStable_r;
   logic [11:0] pinStable_nxt;
   logic [1:0] primeCnt_r;
   logic [1:0] primeCnt_nxt;
   logic primed;
   logic [11:0] pinEdge;
   logic [7:0] tmrLast_r;
   logic [7:0] tmrLast_nxt;
   logic [7:0] tmrRise;
   irq2_flags_pkg::flags_t flags_r;
   irq2_flags_pkg::flags_t flags_nxt;
   irq2_flags_pkg::flags_t mask_r;
   irq2_flags_pkg::flags_t mask_nxt;
   irq2_flags_pkg::flags_t clrBits;
   irq2_flags_pkg::reg_sel_t sel;
   logic apbAccess;
   logic apbCommit;
   logic wrCommit;
   logic [31:0] rdWord;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic irq_r;
   logic irq_nxt;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and either-edge detection
   // low nibble holds pins 17..20, upper byte pins 33..40
   assign pinRaw = {gpioHighPin, gpioLowPin};
   assign primed = (primeCnt_r == `PIN_PRIME_CYCLES);

   always_comb
   begin
      pinMeta_nxt = pinRaw;
      pinSync2_nxt = pinMeta_r;
      pinSync3_nxt = pinSync2_r;
      primeCnt_nxt = primeCnt_r;
      if (!primed)
      begin
         primeCnt_nxt = primeCnt_r + 2'h1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 12; g++)
      begin : gPin
         // a level counts only once the second and third stage agree
         assign pinEdge[g] = primed
            && (pinSync2_r[g] == pinSync3_r[g])
            && (pinSync3_r[g] != pinStable_r[g]);
         // before priming the reference follows stage two, one step ahead
         // of stage three, so a pin high at reset gives no false edge
         assign pinStable_nxt[g] = !primed ? pinSync2_r[g]
            : (pinEdge[g] ? pinSync3_r[g] : pinStable_r[g]);
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinMeta_r <= 12'h000;
         pinSync2_r <= 12'h000;
         pinSync3_r <= 12'h000;
         pinStable_r <= 12'h000;
         primeCnt_r <= 2'h0;
      end
      else
      begin
         pinMeta_r <= pinMeta_nxt;
         pinSync2_r <= pinSync2_nxt;
         pinSync3_r <= pinSync3_nxt;
         pinStable_r <= pinStable_nxt;
         primeCnt_r <= primeCnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer rising-edge detection
   // timer events are same-clock logic, so no synchroniser
   always_comb
   begin
      tmrLast_nxt = tmrEvent;
      tmrRise = tmrEvent & ~tmrLast_r;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tmrLast_r <= 8'h00;
      end
      else
      begin
         tmrLast_r <= tmrLast_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode and handshake
   assign sel = decodeSel(paddr);
   assign apbAccess = psel && penable;
   // the write lands on the edge where the master sees pready high
   assign apbCommit = apbAccess && pready_r;
   assign wrCommit = apbCommit && pwrite;

   always_comb
   begin
      rdWord = 32'h0000_0000;
      case (sel)
         irq2_flags_pkg::SEL_MID_FLAGS:
            rdWord[`PIN20_EDGE_FLAG_BIT:`PIN17_EDGE_FLAG_BIT] =
               flags_r.gpioMid;
         irq2_flags_pkg::SEL_UPPER_FLAGS:
            rdWord[`PIN40_EDGE_FLAG_BIT:`PIN33_EDGE_FLAG_BIT] =
               flags_r.gpioUpper;
         irq2_flags_pkg::SEL_TMR_FLAGS:
            rdWord[`TMR8_RISE_FLAG_BIT:`TMR1_RISE_FLAG_BIT] =
               flags_r.tmr;
         irq2_flags_pkg::SEL_MID_MASK:
            rdWord[3:0] = mask_r.gpioMid;
         irq2_flags_pkg::SEL_UPPER_MASK:
            rdWord[7:0] = mask_r.gpioUpper;
         irq2_flags_pkg::SEL_TMR_MASK:
            rdWord[7:0] = mask_r.tmr;
         default:
            rdWord = 32'h0000_0000;
      endcase
   end

   // one wait state: data and pready come from flops
   always_comb
   begin
      pready_nxt = apbAccess && !pready_r;
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (apbAccess && !pready_r)
      begin
         if (!pwrite)
         begin
            prdata_nxt = rdWord;
         end
         pslverr_nxt = (sel == irq2_flags_pkg::SEL_NONE);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   ////////////////////////////////////////////////////////////////////////
   // sticky flags, write-one-to-clear
   always_comb
   begin
      clrBits = '0;
      if (wrCommit)
      begin
         case (sel)
            irq2_flags_pkg::SEL_MID_FLAGS:
               clrBits.gpioMid = pwdata[3:0];
            irq2_flags_pkg::SEL_UPPER_FLAGS:
               clrBits.gpioUpper = pwdata[7:0];
            irq2_flags_pkg::SEL_TMR_FLAGS:
               clrBits.tmr = pwdata[7:0];
            default:
               clrBits = '0;
         endcase
      end
   end

   // zeros in the write leave a flag alone; an edge in the clear
   // cycle is or-ed in last so it is never lost
   always_comb
   begin
      flags_nxt.gpioMid = (flags_r.gpioMid & ~clrBits.gpioMid)
         | pinEdge[3:0];
      flags_nxt.gpioUpper = (flags_r.gpioUpper & ~clrBits.gpioUpper)
         | pinEdge[11:4];
      flags_nxt.tmr = (flags_r.tmr & ~clrBits.tmr)
         | tmrRise;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flags_r.gpioMid <= `FLAGS_RST_MID;
         flags_r.gpioUpper <= `FLAGS_RST_UPPER;
         flags_r.tmr <= `FLAGS_RST_TMR;
      end
      else
      begin
         flags_r <= flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // masks, a one blocks the flag from the interrupt line
   always_comb
   begin
      mask_nxt = mask_r;
      if (wrCommit)
      begin
         case (sel)
            irq2_flags_pkg::SEL_MID_MASK:
               mask_nxt.gpioMid = pwdata[3:0];
            irq2_flags_pkg::SEL_UPPER_MASK:
               mask_nxt.gpioUpper = pwdata[7:0];
            irq2_flags_pkg::SEL_TMR_MASK:
               mask_nxt.tmr = pwdata[7:0];
            default:
               mask_nxt = mask_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_r.gpioMid <= `MASK_RST_MID;
         mask_r.gpioUpper <= `MASK_RST_UPPER;
         mask_r.tmr <= `MASK_RST_TMR;
      end
      else
      begin
         mask_r <= mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt line
   // built from next values so the line tracks the flags without lag
   always_comb
   begin
      irq_nxt = |(flags_nxt & ~mask_nxt);
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   assign irqOut = irq_r;
endmodule

// [bench/irq2_flags_props.sv]
// port checker for the interrupt flag bank
`timescale 1ns/1ps
`include "irq2_flags_regs.svh"
module irq2_flags_props
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] gpioLowPin,
   input wire logic [7:0] gpioHighPin,
   input wire logic [7:0] tmrEvent,
   input wire logic irqOut
);
   localparam logic [15:0] MID = `BYTE_ADDR(`GPIO_MID_IRQ_FLAGS_IDX);
   localparam logic [15:0] UP = `BYTE_ADDR(`GPIO_UPPER_IRQ_FLAGS_IDX);
   localparam logic [15:0] TMR = `BYTE_ADDR(`TIMER_IRQ_FLAGS_IDX);
   localparam logic [15:0] MIDM = `BYTE_ADDR(`GPIO_MID_IRQ_MASK_IDX);
   localparam logic [15:0] UPM = `BYTE_ADDR(`GPIO_UPPER_IRQ_MASK_IDX);
   localparam logic [15:0] TMRM = `BYTE_ADDR(`TIMER_IRQ_MASK_IDX);
   logic maskOpen_r;
   logic maskOpen_nxt;
   logic rdDone;
   ////////////////////////////////////////////////////////////////////////
   // any mask write counts as unmasking: weaker bound, far less logic
   always_comb
   begin
      rdDone = pready && !pwrite;
      maskOpen_nxt = maskOpen_r || (pready && pwrite && (paddr == MIDM
         || paddr == UPM || paddr == TMRM));
   end
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         maskOpen_r <= 1'b0;
      else
         maskOpen_r <= maskOpen_nxt;
   ////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   wait_state_a: assert property (
      psel && !penable |=> !pready ##1 pready)
      else $error("pready not after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!rdDone |-> prdata == 32'h0)
      else $error("prdata not zero outside read");
   mid_width_a: assert property (
      rdDone && paddr == MID |-> prdata[31:4] == 28'h0)
      else $error("lower gpio word too wide");
   upper_width_a: assert property (
      rdDone && paddr == UP |-> prdata[31:8] == 24'h0)
      else $error("upper gpio word too wide");
   tmr_width_a: assert property (
      rdDone && paddr == TMR |-> prdata[31:8] == 24'h0)
      else $error("timer word too wide");
   masked_quiet_a: assert property (irqOut |-> maskOpen_r)
      else $error("interrupt while all masked");
   cover property (pready && pslverr);
   cover property (irqOut);
   cover property (pready && pwrite && paddr == TMR);
endmodule
bind irq2_gpio_timer_status_flags irq2_flags_props irq2_flags_props_i
(
   .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .gpioLowPin(gpioLowPin),
   .gpioHighPin(gpioHighPin), .tmrEvent(tmrEvent), .irqOut(irqOut)
);

// [bench/testbench.sv]
// self-checking bench for the interrupt flag bank
`timescale 1ns/1ps
`include "irq2_flags_regs.svh"
module testbench;
   localparam logic [15:0] MID = `BYTE_ADDR(`GPIO_MID_IRQ_FLAGS_IDX);
   localparam logic [15:0] UP = `BYTE_ADDR(`GPIO_UPPER_IRQ_FLAGS_IDX);
   localparam logic [15:0] TMR = `BYTE_ADDR(`TIMER_IRQ_FLAGS_IDX);
   localparam logic [15:0] TMRM = `BYTE_ADDR(`TIMER_IRQ_MASK_IDX);
   localparam logic [15:0] MIDM = `BYTE_ADDR(`GPIO_MID_IRQ_MASK_IDX);
   localparam logic [15:0] UPM = `BYTE_ADDR(`GPIO_UPPER_IRQ_MASK_IDX);
   typedef struct packed
   {
      logic [3:0] low;
      logic [7:0] high;
      logic [7:0] tmr;
      logic [15:0] addr;
      logic [31:0] exp;
   } row_t;
   row_t rows[8] = '{'{4'h1, 8'h00, 8'h00, MID, 32'h1},
      '{4'h8, 8'h00, 8'h00, MID, 32'h8}, '{4'h9, 8'h00, 8'h00, MID, 32'h9},
      '{4'h0, 8'h01, 8'h00, UP, 32'h01}, '{4'h0, 8'h80, 8'h00, UP, 32'h80},
      '{4'h0, 8'h81, 8'h00, UP, 32'h81}, '{4'h0, 8'h00, 8'h01, TMR, 32'h1},
      '{4'h0, 8'h00, 8'hfe, TMR, 32'hfe}};
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] gpioLowPin = 4'h0;
   logic [7:0] gpioHighPin = 8'h00;
   logic [7:0] tmrEvent = 8'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irqOut;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int tests_run = 0;
   irq2_gpio_timer_status_flags irq2_gpio_timer_status_flags_i
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gpioLowPin(gpioLowPin),
      .gpioHighPin(gpioHighPin), .tmrEvent(tmrEvent), .irqOut(irqOut)
   );
   ////////////////////////////////////////////////////////////////////////
   initial
   forever #5 clk_sys = ~clk_sys;
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // waits on pready itself; only the watchdog bounds a hung slave
   task automatic apb(input logic wr, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] e,
      input string nm);
      logic [31:0] d;
      logic r;
      apb(1'b0, a, 32'h0, d, r);
      chk(nm, d, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      n_errors++;
      test_done;
   end
   initial
   begin
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         gpioLowPin <= gpioLowPin ^ rows[i].low;
         gpioHighPin <= gpioHighPin ^ rows[i].high;
         tmrEvent <= rows[i].tmr;
         @(posedge clk_sys);
         tmrEvent <= 8'h00;
         repeat (5) @(posedge clk_sys);
         rdchk(rows[i].addr, rows[i].exp, "row flag");
         apb(1'b1, rows[i].addr, rows[i].exp, rd, err);
         rdchk(rows[i].addr, 32'h0, "row clear");
      end
      tmrEvent <= 8'h08;
      repeat (3) @(posedge clk_sys);
      apb(1'b1, TMR, 32'h0, rd, err);
      rdchk(TMR, 32'h8, "zero write");
      apb(1'b1, TMR, 32'h8, rd, err);
      rdchk(TMR, 32'h0, "held level");
      tmrEvent <= 8'h00;
      fork
         apb(1'b1, TMR, 32'h8, rd, err);
         begin
            repeat (3) @(posedge clk_sys);
            tmrEvent <= 8'h08;
         end
      join
      tmrEvent <= 8'h00;
      rdchk(TMR, 32'h8, "set wins");
      chk("irq masked", {31'h0, irqOut}, 32'h0);
      apb(1'b1, TMRM, 32'h0, rd, err);
      chk("mapped err", {31'h0, err}, 32'h0);
      rdchk(TMRM, 32'h0, "mask write");
      repeat (2) @(posedge clk_sys);
      chk("irq raised", {31'h0, irqOut}, 32'h1);
      apb(1'b1, TMR, 32'h8, rd, err);
      repeat (2) @(posedge clk_sys);
      chk("irq cleared", {31'h0, irqOut}, 32'h0);
      apb(1'b0, 16'h0000, 32'h0, rd, err);
      chk("unmapped err", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      gpioHighPin <= gpioHighPin ^ 8'h10;
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("irq after reset", {31'h0, irqOut}, 32'h0);
      rdchk(UP, 32'h0, "reset upper");
      rdchk(MID, 32'h0, "reset mid");
      rdchk(TMR, 32'h0, "reset timer");
      rdchk(MIDM, 32'hf, "reset mid mask");
      rdchk(UPM, 32'hff, "reset upper mask");
      rdchk(TMRM, 32'hff, "reset timer mask");
      test_done;
   end
endmodule
